// ### rtl/gd_pkg.sv
package gd_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_NS = 8;
   localparam int TOGGLE_NS = 56000;
   localparam int PG_LOW_NS = 56000;
   localparam int DEAD_MIN_NS = 40;
   localparam int OC_UNIT_NS = 1750;
   localparam int AMP_UNIT_NS = 500;
   localparam int TOGGLE_CYC = TOGGLE_NS / CLK_NS;
   localparam int PG_LOW_CYC = PG_LOW_NS / CLK_NS;
   localparam int DEAD_UNIT_CYC = (DEAD_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int OC_UNIT_CYC = (OC_UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int AMP_UNIT_CYC = (AMP_UNIT_NS + CLK_NS - 1) / CLK_NS;
   // ****************************************
   // Register indices, byte address is four times the index
   // ****************************************
   localparam logic [5:0] IDX_FAULT_STAT = 6'h01;
   localparam logic [5:0] IDX_WARN_STAT = 6'h02;
   localparam logic [5:0] IDX_TIMING = 6'h07;
   localparam logic [5:0] IDX_CONTROL = 6'h09;
   localparam logic [5:0] IDX_AMP_CFG = 6'h0A;
   localparam logic [5:0] IDX_OC_CFG = 6'h0C;
   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int FS_GLOBAL = 0;
   localparam int FS_TYPE_LSB = 1;
   localparam int FS_WATCHDOG = 0;
   localparam int FS_REG_UV = 1;
   localparam int WS_THERMAL = 5;
   localparam int TM_DEAD_LSB = 4;
   localparam int TM_BLANK_LSB = 2;
   localparam int TM_FILT_LSB = 0;
   localparam int CT_CLEAR = 1;
   localparam int OC_THR_LSB = 3;
   localparam int AC_CAL_LSB = 6;
   localparam int AC_BLANK_LSB = 9;
   localparam logic [6:0] TIMING_RST = 7'h00;
   localparam logic [7:0] OC_CFG_RST = 8'h00;
   localparam logic [10:0] AMP_CFG_RST = 11'h000;
   typedef enum logic [2:0] {
      OC_LATCH,
      OC_REPORT,
      OC_OFF
   } oc_mode_e;
endpackage

// ### rtl/gate_driver_fault_supervisor.sv
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - Any gate output edge blanks all three amplifiers; new edge restarts blanking.
// - Amplifier blanking field value zero means no blanking, and is the reset value.
// - Calibration enable shorts amplifier inputs and disconnects load, any time.
// - Each amplifier has its own two-bit gain: 10, 20, 40, 80 V/V.
// - Regulator crossing drives power good low 56 us, then while still bad.
// - Warning sets status and toggles fault pin 56 us low/high; gates untouched.
// - Reading warning status stops toggling; status stays while condition lasts.
// - Same warning signals again only after it clears and recurs.
// - Fault holds fault pin low, sets global bit and type bit at 0x1.
// - A fault overrides warning toggling, latches pin low, shuts gates.
// - Faults latch, shut gates and leave all MOSFETs off until recovery.
// - Recovery: condition gone, then clear-faults bit D1 of 0x9 or enable pulse.
// - Clear-faults bit returns to zero once faults are reset and pin released.
// - Thermal flags never touch fault pin; status follows them live.
// - Watchdog and regulator undervoltage faults also pull power good low.
// - Opposite MOSFET turns on only after handshake shows cutoff.
// - At least 40 ns digital dead time after handshake, set by 0x7 D6-D4.
// - Drain-source comparators ignored for blanking time 0x7 D3-D2 after turn-on.
// - Trip must persist deglitch time 0x7 D1-D0 to count.
// - Response mode from 0xC D2-D0; threshold 0xC D7-D3 changeable anytime.
// - Latched mode: overcurrent pulls all gates low, reports, names the MOSFET.
// - Report mode: overcurrent reported on pin and status, gates keep running.
// - Disabled mode: overcurrent detections neither acted on nor reported.
module gate_driver_fault_supervisor
   import gd_pkg::*;
#(
   parameter int TOGGLE_CYCLES = TOGGLE_CYC,
   parameter int PG_CYCLES = PG_LOW_CYC,
   parameter int NWARN = 4,
   parameter int NFLT = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] gate_cmd,
   input wire logic gate_enable,
   input wire logic [5:0] gate_cutoff,
   input wire logic [5:0] drain_source_trip,
   input wire logic [NWARN-1:0] warning_cond,
   input wire logic [NFLT-1:0] fault_cond,
   input wire logic thermal_flag,
   input wire logic regulator_output_bad,
   output logic [5:0] gate_out,
   output logic mosfet_hiz,
   output logic fault_out_n_o,
   output logic fault_out_n_oe,
   output logic power_good_out,
   output logic amp_blank,
   output logic [5:0] amp_gain,
   output logic [2:0] amp_cal,
   output logic [4:0] drain_source_threshold
);
   // ****************************************
   // Checks and constants
   // ****************************************
   localparam int NS = 6 + 1 + 6 + 6 + NWARN + NFLT + 2;
   localparam int NF = 6 + NFLT;
   localparam int NW = NWARN + 1;
   // The power good hold must outlast the eight cycles that its assertion watches.
   if (TOGGLE_CYCLES < 2 || TOGGLE_CYCLES > 8191 || PG_CYCLES < 8 || PG_CYCLES > 8191 ||
       NFLT < 2 || NWARN < 1 || NFLT + NWARN > 20) begin : g_param_check
      $error("Unsupported parameter values.");
   end

   function automatic logic [9:0] scale(input int unit, input logic [2:0] f);
      scale = 10'(unit * (int'(f) + 1));
   endfunction

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [NS-1:0] sync1_r;
   logic [NS-1:0] sync2_r;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {gate_cmd, gate_enable, gate_cutoff, drain_source_trip, warning_cond,
                     fault_cond, thermal_flag, regulator_output_bad};
         sync2_r <= sync1_r;
      end
   end
   logic [5:0] cmd_s, cut_s, trip_s;
   logic en_s, therm_s, regbad_s;
   logic [NWARN-1:0] warn_s;
   logic [NFLT-1:0] flt_s;
   assign {cmd_s, en_s, cut_s, trip_s, warn_s, flt_s, therm_s, regbad_s} = sync2_r;

   // ****************************************
   // Register file
   // ****************************************
   logic [6:0] timing_r;
   logic [7:0] oc_cfg_r;
   logic [10:0] amp_cfg_r;
   logic clear_faults_r;
   logic [NF-1:0] fstat_r;
   logic [NW-1:0] wstat_r;
   logic [5:0] idx;
   logic hit, wr_acc, rd_acc, wread;
   assign idx = paddr[7:2];
   assign hit = paddr[1:0] == 2'b00 && (idx == IDX_FAULT_STAT || idx == IDX_WARN_STAT ||
                idx == IDX_TIMING || idx == IDX_CONTROL || idx == IDX_AMP_CFG ||
                idx == IDX_OC_CFG);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign wr_acc = psel && penable && pwrite && hit;
   assign rd_acc = psel && penable && !pwrite && hit;
   assign wread = rd_acc && idx == IDX_WARN_STAT;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timing_r <= TIMING_RST;
         oc_cfg_r <= OC_CFG_RST;
         amp_cfg_r <= AMP_CFG_RST;
      end else if (wr_acc) begin
         if (idx == IDX_TIMING)
            timing_r <= pwdata[6:0];
         if (idx == IDX_OC_CFG)
            oc_cfg_r <= pwdata[7:0];
         if (idx == IDX_AMP_CFG)
            amp_cfg_r <= pwdata[10:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata <= '0;
      end else if (psel && !penable) begin
         unique case (hit ? idx : 6'h00)
            IDX_FAULT_STAT: prdata <= 32'({fstat_r, |fstat_r});
            IDX_WARN_STAT: prdata <= 32'({therm_s, wstat_r});
            IDX_TIMING: prdata <= 32'(timing_r);
            IDX_CONTROL: prdata <= 32'({clear_faults_r, 1'b0});
            IDX_AMP_CFG: prdata <= 32'(amp_cfg_r);
            IDX_OC_CFG: prdata <= 32'(oc_cfg_r);
            default: prdata <= '0;
         endcase
      end
   end

   // ****************************************
   // Amplifier control
   // ****************************************
   logic [5:0] gprev_r;
   logic [9:0] ablank_r;
   assign amp_gain = amp_cfg_r[5:0];
   assign amp_cal = amp_cfg_r[AC_CAL_LSB+:3];
   assign drain_source_threshold = oc_cfg_r[OC_THR_LSB+:5];
   assign amp_blank = ablank_r != 10'h000;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         gprev_r <= '0;
         ablank_r <= '0;
      end else begin
         gprev_r <= gate_out;
         if (gate_out != gprev_r && amp_cfg_r[AC_BLANK_LSB+:2] != 2'b00)
            ablank_r <= 10'(AMP_UNIT_CYC * int'(amp_cfg_r[AC_BLANK_LSB+:2]));
         else if (ablank_r != 10'h000)
            ablank_r <= ablank_r - 10'h001;
      end
   end

   // ****************************************
   // Gate sequencing with handshake and dead time
   // ****************************************
   logic fault_any, run;
   logic [9:0] dead_cyc;
   logic [9:0] dead_r [3];
   logic [9:0] dead_nxt [3];
   logic [5:0] gate_nxt;
   assign fault_any = |fstat_r;
   assign run = en_s && !fault_any;
   assign mosfet_hiz = fault_any;
   assign dead_cyc = scale(DEAD_UNIT_CYC, timing_r[TM_DEAD_LSB+:3]);

   always_comb begin
      logic both_off, settled;
      both_off = 1'b0;
      settled = 1'b0;
      for (int p = 0; p < 3; p++) begin
         both_off = !gate_out[2*p] && !gate_out[2*p+1];
         if (both_off && cut_s[2*p] && cut_s[2*p+1])
            dead_nxt[p] = dead_r[p] == 10'h3FF ? dead_r[p] : dead_r[p] + 10'h001;
         else
            dead_nxt[p] = '0;
         settled = both_off && cut_s[2*p] && cut_s[2*p+1] && dead_r[p] >= dead_cyc;
         gate_nxt[2*p] = run && cmd_s[2*p] && !cmd_s[2*p+1] && (gate_out[2*p] || settled);
         gate_nxt[2*p+1] = run && cmd_s[2*p+1] && !cmd_s[2*p] && (gate_out[2*p+1] || settled);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         gate_out <= '0;
         for (int p = 0; p < 3; p++)
            dead_r[p] <= '0;
      end else begin
         gate_out <= gate_nxt;
         for (int p = 0; p < 3; p++)
            dead_r[p] <= dead_nxt[p];
      end
   end

   // ****************************************
   // Overcurrent blanking, deglitch and response
   // ****************************************
   logic [9:0] ocb_r [6];
   logic [9:0] ocf_r [6];
   logic [5:0] oc_det;
   logic [9:0] ocb_cyc, ocf_cyc;
   logic mode_latch, mode_report;
   assign ocb_cyc = scale(OC_UNIT_CYC, {1'b0, timing_r[TM_BLANK_LSB+:2]});
   assign ocf_cyc = scale(OC_UNIT_CYC, {1'b0, timing_r[TM_FILT_LSB+:2]});
   assign mode_latch = oc_cfg_r[2:0] == 3'(OC_LATCH);
   assign mode_report = oc_cfg_r[2:0] == 3'(OC_REPORT);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < 6; i++) begin
            ocb_r[i] <= '0;
            ocf_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (gate_out[i] && !gprev_r[i])
               ocb_r[i] <= ocb_cyc;
            else if (ocb_r[i] != 10'h000)
               ocb_r[i] <= ocb_r[i] - 10'h001;
            if (trip_s[i] && gate_out[i] && ocb_r[i] == 10'h000 && (mode_latch || mode_report))
               ocf_r[i] <= ocf_r[i] == 10'h3FF ? ocf_r[i] : ocf_r[i] + 10'h001;
            else
               ocf_r[i] <= '0;
         end
      end
   end
   always_comb begin
      for (int i = 0; i < 6; i++)
         oc_det[i] = ocf_r[i] >= ocf_cyc;
   end

   // ****************************************
   // Fault latching and recovery
   // ****************************************
   logic [NF-1:0] fcond;
   logic en_prev_r, do_clear;
   assign fcond = {oc_det & {6{mode_latch}}, flt_s};
   assign do_clear = (clear_faults_r || (en_prev_r && !en_s)) && !(|fcond);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fstat_r <= '0;
         en_prev_r <= 1'b0;
         clear_faults_r <= 1'b0;
      end else begin
         en_prev_r <= en_s;
         fstat_r <= (fstat_r & {NF{!do_clear}}) | fcond;
         if (wr_acc && idx == IDX_CONTROL)
            clear_faults_r <= pwdata[CT_CLEAR];
         else if (clear_faults_r && !fault_any)
            clear_faults_r <= 1'b0;
      end
   end

   // ****************************************
   // Warnings and fault pin
   // ****************************************
   logic [NW-1:0] wcond, wprev_r, pend_r;
   logic [12:0] tog_r;
   logic tog_low_r;
   assign wcond = {mode_report && |oc_det, warn_s};

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wprev_r <= '0;
         pend_r <= '0;
         wstat_r <= '0;
      end else begin
         wprev_r <= wcond;
         pend_r <= (pend_r & {NW{!wread}}) | (wcond & ~wprev_r);
         wstat_r <= wcond | (wstat_r & pend_r & {NW{!wread}});
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tog_r <= '0;
         tog_low_r <= 1'b0;
         fault_out_n_oe <= 1'b0;
      end else begin
         if (!(|pend_r)) begin
            tog_r <= '0;
            tog_low_r <= 1'b1;
         end else if (tog_r == 13'(TOGGLE_CYCLES - 1)) begin
            tog_r <= '0;
            tog_low_r <= !tog_low_r;
         end else begin
            tog_r <= tog_r + 13'h0001;
         end
         fault_out_n_oe <= fault_any || (|pend_r && tog_low_r);
      end
   end
   assign fault_out_n_o = 1'b0;

   // ****************************************
   // Power good
   // ****************************************
   logic regbad_prev_r;
   logic [12:0] pg_r;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         regbad_prev_r <= 1'b0;
         pg_r <= '0;
         power_good_out <= 1'b1;
      end else begin
         regbad_prev_r <= regbad_s;
         if (regbad_s && !regbad_prev_r)
            pg_r <= 13'(PG_CYCLES);
         else if (pg_r != 13'h0000)
            pg_r <= pg_r - 13'h0001;
         power_good_out <= !((pg_r != 13'h0000) || regbad_s ||
                             fstat_r[FS_WATCHDOG] ||
                             fstat_r[FS_REG_UV]);
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_amp_blank_restart;
      @(posedge clock) disable iff (!rst_n)
         (gate_out != gprev_r && amp_cfg_r[10:9] != 2'b00) |=> amp_blank;
   endproperty
   a_amp_blank_restart: assert property (p_amp_blank_restart) else $error("No blanking.");

   property p_amp_no_blank;
      @(posedge clock) disable iff (!rst_n)
         (amp_cfg_r[10:9] == 2'b00 && ablank_r == 10'h000) |=> !amp_blank;
   endproperty
   a_amp_no_blank: assert property (p_amp_no_blank) else $error("Blank at zero.");

   property p_fault_pin;
      @(posedge clock) disable iff (!rst_n) fault_any |=> fault_out_n_oe;
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("Fault pin not low.");

   property p_fault_gates;
      @(posedge clock) disable iff (!rst_n) fault_any |=> gate_out == 6'h00;
   endproperty
   a_fault_gates: assert property (p_fault_gates) else $error("Gates on in fault.");

   property p_no_shoot;
      @(posedge clock) disable iff (!rst_n)
         !(gate_out[0] && gate_out[1]) && !(gate_out[2] && gate_out[3]) &&
         !(gate_out[4] && gate_out[5]);
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("Shoot-through.");

   property p_dead_time;
      @(posedge clock) disable iff (!rst_n)
         $rose(gate_out[1]) |-> $past(dead_r[0]) >= dead_cyc && dead_cyc >= 10'h005;
   endproperty
   a_dead_time: assert property (p_dead_time) else $error("Dead time short.");

   property p_clear_self;
      @(posedge clock) disable iff (!rst_n)
         (clear_faults_r && !fault_any && !(wr_acc && idx == IDX_CONTROL)) |=> !clear_faults_r;
   endproperty
   a_clear_self: assert property (p_clear_self) else $error("Clear bit stuck.");

   property p_pg_low;
      @(posedge clock) disable iff (!rst_n)
         (regbad_s && !regbad_prev_r) |=> ##1 !power_good_out [*8];
   endproperty
   a_pg_low: assert property (p_pg_low) else $error("Power good not low.");

   property p_warn_quiet;
      @(posedge clock) disable iff (!rst_n)
         (!fault_any && pend_r == '0) |=> !fault_out_n_oe;
   endproperty
   a_warn_quiet: assert property (p_warn_quiet) else $error("Pin low idle.");

   property p_oc_disabled;
      @(posedge clock) disable iff (!rst_n) (!mode_latch && !mode_report) |=> ##1 oc_det == 6'h00
         || ocf_cyc == 10'h000;
   endproperty
   a_oc_disabled: assert property (p_oc_disabled) else $error("Overcurrent seen.");
endmodule

// ### sim/mcu_model.sv
`timescale 1ns/10ps
// ****************************************
// Controller and power stage stand-in
// ****************************************
module mcu_model (
   input wire logic clock,
   input wire logic [5:0] gate_out,
   input wire logic fault_out_n_o,
   input wire logic fault_out_n_oe,
   input wire logic hold_on,
   output logic [5:0] gate_cutoff,
   output logic fault_line
);
   // The fault pin is open drain, so the pull-up wins whenever nobody pulls it low.
   assign fault_line = fault_out_n_oe ? fault_out_n_o : 1'b1;
   // A stalled stage keeps every gate above cutoff, so no handshake can complete.
   always_ff @(posedge clock) begin
      gate_cutoff <= hold_on ? 6'h00 : ~gate_out;
   end
endmodule

// ### sim/tb_gate_driver_fault_supervisor.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin num_errors++; $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module tb_gate_driver_fault_supervisor
   import gd_pkg::*;
;
   localparam logic [7:0] A_FS = {IDX_FAULT_STAT, 2'b00};
   localparam logic [7:0] A_WS = {IDX_WARN_STAT, 2'b00};
   localparam logic [7:0] A_TM = {IDX_TIMING, 2'b00};
   localparam logic [7:0] A_CT = {IDX_CONTROL, 2'b00};
   localparam logic [7:0] A_AC = {IDX_AMP_CFG, 2'b00};
   localparam logic [7:0] A_OC = {IDX_OC_CFG, 2'b00};
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err, hold_on;
   logic gate_enable, thermal_flag, regulator_output_bad, mosfet_hiz, fault_line;
   logic fault_out_n_o, fault_out_n_oe, power_good_out, amp_blank;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] gate_cmd, gate_cutoff, drain_source_trip, gate_out, amp_gain, g;
   logic [3:0] warning_cond, fault_cond;
   logic [2:0] amp_cal;
   logic [4:0] drain_source_threshold;
   logic [7:0] regs [6] = '{A_FS, A_WS, A_TM, A_CT, A_AC, A_OC};
   int num_errors, compares, cyc, n;

   gate_driver_fault_supervisor #(.TOGGLE_CYCLES(20), .PG_CYCLES(20)) u_dut (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gate_cmd(gate_cmd), .gate_enable(gate_enable), .gate_cutoff(gate_cutoff),
      .drain_source_trip(drain_source_trip), .warning_cond(warning_cond),
      .fault_cond(fault_cond), .thermal_flag(thermal_flag),
      .regulator_output_bad(regulator_output_bad), .gate_out(gate_out),
      .mosfet_hiz(mosfet_hiz), .fault_out_n_o(fault_out_n_o),
      .fault_out_n_oe(fault_out_n_oe), .power_good_out(power_good_out),
      .amp_blank(amp_blank), .amp_gain(amp_gain), .amp_cal(amp_cal),
      .drain_source_threshold(drain_source_threshold));

   mcu_model u_mcu (.clock(clock), .gate_out(gate_out), .fault_out_n_o(fault_out_n_o),
      .fault_out_n_oe(fault_out_n_oe), .hold_on(hold_on), .gate_cutoff(gate_cutoff),
      .fault_line(fault_line));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] ex);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(nm, ex, rd & m)
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: sig = fault_line;
         1: sig = power_good_out;
         2: sig = amp_blank;
         3: sig = gate_out[0];
         default: sig = gate_out[1];
      endcase
   endfunction

   // Counts the cycles until the chosen signal shows the wanted level, up to a limit.
   task automatic wait_val(input int k, input logic v, input int lim, output int c);
      c = 0;
      while (sig(k) !== v && c < lim) begin
         @(posedge clock);
         c++;
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      {rst_n, psel, penable, pwrite, hold_on, thermal_flag, regulator_output_bad} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      gate_enable = 1'b1;
      {gate_cmd, drain_source_trip, warning_cond, fault_cond} = '0;
      tick(20);
      rst_n <= 1'b1;
      tick(3);
      `CHK("power good", 1'b1, power_good_out)
      `CHK("fault pin", 1'b1, fault_line)
      `CHK("amp blank", 1'b0, amp_blank)
      foreach (regs[i]) rd_chk("reset value", regs[i], 32'hFFFF_FFFF, 32'h0);
      apb(1'b0, 8'h3C, 32'h0000_0000);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h0000_0000, rd)
      $display("Test reset done");
      for (int i = 0; i < 4; i++) begin
         g = {2'(i), 2'(i + 1), 2'(i + 2)};
         apb(1'b1, A_AC, {21'h0, 2'b00, 3'(i), g});
         `CHK("gain", g, amp_gain)
         `CHK("calibration", 3'(i), amp_cal)
      end
      apb(1'b1, A_AC, 32'h0000_0200);
      $display("Test amplifier done");
      apb(1'b1, A_TM, 32'h0000_0020);
      gate_cmd <= 6'h02;
      wait_val(4, 1'b1, 50, n);
      hold_on <= 1'b1;
      gate_cmd <= 6'h01;
      wait_val(4, 1'b0, 50, n);
      tick(40);
      `CHK("high side held", 1'b0, gate_out[0])
      hold_on <= 1'b0;
      wait_val(3, 1'b1, 60, n);
      `CHK("dead time", 1'b1, n >= 15 && n <= 23)
      wait_val(2, 1'b0, 100, n);
      `CHK("amp blank length", 1'b1, n >= 60 && n <= 66)
      $display("Test handshake done");
      apb(1'b1, A_OC, 32'h0000_00A8);
      `CHK("threshold", 5'h15, drain_source_threshold)
      `CHK("gate runs", 1'b1, gate_out[0])
      gate_cmd <= 6'h00;
      tick(30);
      drain_source_trip <= 6'h01;
      gate_cmd <= 6'h01;
      wait_val(3, 1'b1, 60, n);
      wait_val(0, 1'b0, 350, n);
      `CHK("trip masked", 350, n)
      wait_val(0, 1'b0, 200, n);
      `CHK("trip latched", 1'b1, n < 200)
      tick(2);
      `CHK("gates off", 6'h00, gate_out)
      `CHK("high impedance", 1'b1, mosfet_hiz)
      rd_chk("fault status", A_FS, 32'hFFFF_FFFF, 32'h0000_0021);
      drain_source_trip <= 6'h00;
      tick(5);
      `CHK("still latched", 1'b0, fault_line)
      apb(1'b1, A_CT, 32'h0000_0002);
      tick(3);
      `CHK("released", 1'b1, fault_line)
      rd_chk("fault cleared", A_FS, 32'hFFFF_FFFF, 32'h0);
      rd_chk("clear bit", A_CT, 32'h0000_0002, 32'h0);
      tick(450);
      drain_source_trip <= 6'h01;
      tick(100);
      drain_source_trip <= 6'h00;
      tick(20);
      `CHK("short trip", 1'b1, fault_line)
      apb(1'b1, A_OC, 32'h0000_00A9);
      drain_source_trip <= 6'h01;
      wait_val(0, 1'b0, 300, n);
      `CHK("report pin", 1'b1, n < 300)
      `CHK("report gates", 6'h01, gate_out)
      drain_source_trip <= 6'h00;
      rd_chk("report status", A_WS, 32'h10, 32'h10);
      tick(3);
      wait_val(0, 1'b0, 60, n);
      `CHK("toggle stopped", 60, n)
      apb(1'b1, A_OC, 32'h0000_00AA);
      drain_source_trip <= 6'h01;
      wait_val(0, 1'b0, 400, n);
      `CHK("disabled pin", 400, n)
      `CHK("disabled gates", 6'h01, gate_out)
      rd_chk("disabled fault", A_FS, 32'hFFFF_FFFF, 32'h0);
      rd_chk("disabled warning", A_WS, 32'h10, 32'h0);
      drain_source_trip <= 6'h00;
      $display("Test overcurrent done");
      warning_cond <= 4'h1;
      wait_val(0, 1'b0, 20, n);
      wait_val(0, 1'b1, 40, n);
      `CHK("warning low time", 1'b1, n >= 19 && n <= 21)
      wait_val(0, 1'b0, 40, n);
      `CHK("warning high time", 1'b1, n >= 19 && n <= 21)
      `CHK("warning gates", 6'h01, gate_out)
      rd_chk("warning status", A_WS, 32'h1, 32'h1);
      tick(3);
      wait_val(0, 1'b0, 60, n);
      `CHK("warning silenced", 60, n)
      rd_chk("warning held", A_WS, 32'h1, 32'h1);
      warning_cond <= 4'h0;
      tick(5);
      rd_chk("warning gone", A_WS, 32'h1, 32'h0);
      warning_cond <= 4'h1;
      wait_val(0, 1'b0, 20, n);
      `CHK("warning again", 1'b1, n < 20)
      fault_cond <= 4'h4;
      tick(10);
      wait_val(0, 1'b1, 100, n);
      `CHK("fault wins", 100, n)
      `CHK("fault gates", 6'h00, gate_out)
      rd_chk("fault type", A_FS, 32'h1F, 32'h09);
      {fault_cond, warning_cond} <= '0;
      tick(5);
      apb(1'b0, A_WS, 32'h0000_0000);
      gate_enable <= 1'b0;
      tick(2);
      gate_enable <= 1'b1;
      tick(5);
      `CHK("enable pulse clear", 1'b1, fault_line)
      `CHK("hiz off", 1'b0, mosfet_hiz)
      $display("Test warning done");
      thermal_flag <= 1'b1;
      tick(5);
      rd_chk("thermal on", A_WS, 32'h20, 32'h20);
      wait_val(0, 1'b0, 60, n);
      `CHK("thermal pin", 60, n)
      thermal_flag <= 1'b0;
      tick(5);
      rd_chk("thermal off", A_WS, 32'h20, 32'h0);
      $display("Test thermal done");
      regulator_output_bad <= 1'b1;
      tick(3);
      regulator_output_bad <= 1'b0;
      wait_val(1, 1'b0, 10, n);
      wait_val(1, 1'b1, 40, n);
      `CHK("power good low time", 1'b1, n >= 19 && n <= 22)
      regulator_output_bad <= 1'b1;
      wait_val(1, 1'b0, 10, n);
      tick(50);
      `CHK("power good held", 1'b0, power_good_out)
      regulator_output_bad <= 1'b0;
      wait_val(1, 1'b1, 40, n);
      `CHK("power good back", 1'b1, power_good_out)
      for (int i = 1; i < 3; i++) begin
         fault_cond <= 4'(i);
         tick(6);
         `CHK("fault power good", 1'b0, power_good_out)
         `CHK("fault pin low", 1'b0, fault_line)
         fault_cond <= 4'h0;
         tick(3);
         apb(1'b1, A_CT, 32'h0000_0002);
         tick(4);
         `CHK("power good restored", 1'b1, power_good_out)
      end
      $display("Test power good done");
      finish_test();
   end
endmodule
